// ===== rtl/itc_pkg.sv
// Purpose: Shared constants for the integrator test and clock control pair.
// Assumes: One system clock at 25 MHz drives both ends.
// Notes: Charge scale and conversion length are modelling choices, kept here as constants.
package itc_pkg;
    localparam int SYS_CLK_NS = 40;
    localparam int NUM_CH = 4;
    localparam int RES_W = 20;
    localparam int IN_W = 16;
    localparam int FRAME_WORDS = 2 * NUM_CH;
    localparam int FRAME_BITS = FRAME_WORDS * RES_W;
    localparam int DIV_QUARTER = 4;
    localparam int DIV_ONE = 1;
    localparam int PACKET_PC = 11;
    localparam int CODE_PER_PC = 4096;
    localparam logic [RES_W-1:0] PACKET_CODE = RES_W'(PACKET_PC * CODE_PER_PC);
    localparam int SIDE_SELECT_TICKS = 24;
    localparam int TEST_SETUP_NS = 100;
    localparam int TEST_EDGE_TO_SIDE_NS = 1000;
    localparam int TEST_LOW_NS = 1000;
    localparam int TEST_HIGH_NS = 1000;
    localparam int AGE_W = 8;
    localparam logic [AGE_W-1:0] SETUP_AGE = AGE_W'((TEST_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [AGE_W-1:0] EDGE_TO_SIDE_AGE = AGE_W'((TEST_EDGE_TO_SIDE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [AGE_W-1:0] TEST_LOW_AGE = AGE_W'((TEST_LOW_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [AGE_W-1:0] TEST_HIGH_AGE = AGE_W'((TEST_HIGH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [2:0] SHIFT_HALF_LAST = 3'h3;
    localparam logic [2:0] DISCARD_FRAMES = 3'h4;
    localparam int FIFO_DEPTH = 4;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam int CTRL_SIDE_BIT = 0;
    localparam int CTRL_TEST_BIT = 1;
    localparam int CTRL_DIV_BIT = 2;
    localparam int CMD_PULSE_BIT = 0;
    localparam logic [2:0] CTRL_RESET = 3'h0;
endpackage

// ===== rtl/itc_if.sv
// Purpose: Control pins between the converter and its controller.
// Assumes: The bench joins both modports; the controller ties the cascade line low.
// Notes: All signals are plain levels; no clock travels here.
`timescale 1ns/10ps
interface itc_if;
    logic sideSelect;
    logic testPin;
    logic sysclkQuarterDividerSelect;
    logic serialShiftClock;
    logic cascadeIn;
    logic serialDataOut;
    logic resultReadyN;
    modport dev (
        input sideSelect,
        input testPin,
        input sysclkQuarterDividerSelect,
        input serialShiftClock,
        input cascadeIn,
        output serialDataOut,
        output resultReadyN
    );
    modport host (
        output sideSelect,
        output testPin,
        output sysclkQuarterDividerSelect,
        output serialShiftClock,
        output cascadeIn,
        input serialDataOut,
        input resultReadyN
    );
endinterface

// ===== rtl/itc_device.sv
// Purpose: Converter end: integrators, test mode, clock divider and result shift path.
// Assumes: Link pins are asynchronous and pass two flip-flops before use.
// Notes: Charge is modelled as codes per internal clock tick, not as analog current.
`timescale 1ns/10ps

// Overview of operation
// - Test high at side edge enters test mode.
// - Test held whole period gives zero result.
// - Each test rise adds fixed eleven picocoulomb packet.
// - Controller pulses test low-high before side edge.
// - Controller waits one microsecond after test rise.
// - Test low and high each one microsecond.
// - Test mode alike in continuous, non-continuous modes.
// - Readout unchanged during test mode.
// - Exit by test low; discard following results.
// - Divider select high divides clock by four.
// - Shift clock low after readout, side edges.
// - Conversion independent of readout shift clock.
// - Cascade input only feeds daisy-chain shift path.
// - Side edges synchronous to system clock.
// - Side select low integrates B, high A.
// - Result ready low once both sides valid.
module itc_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Control pins from the controller
    itc_if.dev link,
    // Input charge per internal tick, one per channel
    input wire logic [itc_pkg::IN_W-1:0] currentInputOne,
    input wire logic [itc_pkg::IN_W-1:0] currentInputTwo,
    input wire logic [itc_pkg::IN_W-1:0] currentInputThree,
    input wire logic [itc_pkg::IN_W-1:0] currentInputFour,
    // Status
    output logic testModeActive,
    output logic integratingSideA,
    output logic nonContinuous
);
    import itc_pkg::*;

    localparam logic [1:0] DIV_LAST = 2'(DIV_QUARTER - 1);
    localparam logic [4:0] SIDE_SELECT_LOAD = 5'(SIDE_SELECT_TICKS);
    localparam logic [7:0] FRAME_LOAD = 8'(FRAME_BITS);

    function automatic logic [RES_W-1:0] satAdd(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
        logic [RES_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        satAdd = s[RES_W] ? {RES_W{1'b1}} : s[RES_W-1:0];
    endfunction

    logic [4:0] rawIn;
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic sideLvl;
    logic testLvl;
    logic quarterSel;
    logic shiftLvl;
    logic cascLvl;
    logic sidePrev_q;
    logic testPrev_q;
    logic shiftPrev_q;
    logic sideEdge;
    logic testRise;
    logic shiftRise;
    logic [1:0] divCnt_q;
    logic tick;
    logic testMode_q;
    logic [4:0] convCnt_q;
    logic ncont_q;
    logic grounded;
    logic [IN_W-1:0] chIn [NUM_CH];
    logic [FRAME_BITS-1:0] frame;
    logic capA;
    logic capB;
    logic validA_q;
    logic validB_q;
    logic load;
    logic [FRAME_BITS-1:0] shift_q;
    logic [7:0] bitCnt_q;
    logic readyN_q;

    assign rawIn = {link.cascadeIn, link.serialShiftClock, link.sysclkQuarterDividerSelect,
                    link.testPin, link.sideSelect};

    // Pins come from another party, so they settle before any decoding.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
        end else begin
            meta_q <= rawIn;
            sync_q <= meta_q;
        end
    end

    assign sideLvl = sync_q[0];
    assign testLvl = sync_q[1];
    assign quarterSel = sync_q[2];
    assign shiftLvl = sync_q[3];
    assign cascLvl = sync_q[4];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sidePrev_q <= 1'b0;
            testPrev_q <= 1'b0;
            shiftPrev_q <= 1'b0;
        end else begin
            sidePrev_q <= sideLvl;
            testPrev_q <= testLvl;
            shiftPrev_q <= shiftLvl;
        end
    end

    assign sideEdge = sideLvl ^ sidePrev_q;
    assign testRise = testLvl & ~testPrev_q;
    assign shiftRise = shiftLvl & ~shiftPrev_q;

    // The divider phase is free running; its relation to side edges is arbitrary.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q <= 2'h0;
        end else if (divCnt_q == DIV_LAST) begin
            divCnt_q <= 2'h0;
        end else begin
            divCnt_q <= divCnt_q + 2'h1;
        end
    end

    assign tick = quarterSel ? (divCnt_q == DIV_LAST) : 1'b1;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            testMode_q <= 1'b0;
        end else if (sideEdge) begin
            testMode_q <= testLvl;
        end
    end

    // A side edge while the previous conversion is busy drops into non-continuous mode.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            convCnt_q <= 5'h00;
            ncont_q <= 1'b0;
        end else if (sideEdge) begin
            convCnt_q <= SIDE_SELECT_LOAD;
            if (convCnt_q != 5'h00) begin
                ncont_q <= 1'b1;
            end
        end else if (tick && convCnt_q != 5'h00) begin
            convCnt_q <= convCnt_q - 5'h01;
            if (convCnt_q == 5'h01) begin
                ncont_q <= 1'b0;
            end
        end
    end

    assign grounded = testMode_q | ncont_q;

    assign chIn[0] = currentInputOne;
    assign chIn[1] = currentInputTwo;
    assign chIn[2] = currentInputThree;
    assign chIn[3] = currentInputFour;

    assign capA = sideEdge & sidePrev_q;
    assign capB = sideEdge & ~sidePrev_q;

    for (genvar c = 0; c < NUM_CH; c++) begin : gCh
        logic [RES_W-1:0] accA_q;
        logic [RES_W-1:0] accB_q;
        logic [RES_W-1:0] resA_q;
        logic [RES_W-1:0] resB_q;
        logic [RES_W-1:0] inTerm;
        logic [RES_W-1:0] pktTerm;
        logic [RES_W-1:0] cur;
        logic [RES_W-1:0] nxt;

        assign inTerm = (tick && !grounded) ? RES_W'(chIn[c]) : {RES_W{1'b0}};
        // Packets count in either integration mode and ignore the tick rate.
        assign pktTerm = (testMode_q && testRise) ? PACKET_CODE : {RES_W{1'b0}};
        assign cur = sideLvl ? accA_q : accB_q;
        assign nxt = satAdd(satAdd(cur, inTerm), pktTerm);

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                accA_q <= {RES_W{1'b0}};
                accB_q <= {RES_W{1'b0}};
                resA_q <= {RES_W{1'b0}};
                resB_q <= {RES_W{1'b0}};
            end else if (capA) begin
                resA_q <= accA_q;
                accA_q <= {RES_W{1'b0}};
            end else if (capB) begin
                resB_q <= accB_q;
                accB_q <= {RES_W{1'b0}};
            end else if (sideLvl) begin
                accA_q <= nxt;
            end else begin
                accB_q <= nxt;
            end
        end

        assign frame[FRAME_BITS-1-2*c*RES_W -: RES_W] = resA_q;
        assign frame[FRAME_BITS-1-(2*c+1)*RES_W -: RES_W] = resB_q;
    end

    // A fresh frame may replace one whose readout has not started yet.
    assign load = validA_q & validB_q & ((bitCnt_q == 8'h00) | ~readyN_q);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            validA_q <= 1'b0;
            validB_q <= 1'b0;
        end else begin
            validA_q <= capA | (validA_q & ~load);
            validB_q <= capB | (validB_q & ~load);
        end
    end

    // Shifting runs on the shift clock alone, whatever the test or conversion state.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= {FRAME_BITS{1'b0}};
            bitCnt_q <= 8'h00;
            readyN_q <= 1'b1;
        end else if (load) begin
            shift_q <= frame;
            bitCnt_q <= FRAME_LOAD;
            readyN_q <= 1'b0;
        end else if (shiftRise) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], cascLvl};
            readyN_q <= 1'b1;
            if (bitCnt_q != 8'h00) begin
                bitCnt_q <= bitCnt_q - 8'h01;
            end
        end
    end

    assign link.serialDataOut = shift_q[FRAME_BITS-1];
    assign link.resultReadyN = readyN_q;
    assign testModeActive = testMode_q;
    assign integratingSideA = sideLvl;
    assign nonContinuous = ncont_q;
endmodule

// ===== rtl/itc_host.sv
// Purpose: Controller end: drives side select, test pin and shift clock under APB control.
// Assumes: FIFO depth is a power of two; the device answers within a half shift period.
// Notes: Results wait in a small FIFO; a full FIFO stops the shift clock.
`timescale 1ns/10ps
module itc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign inReady = count_q != FULL;
    assign outValid = count_q != '0;
    assign outData = mem_q[rdPtr_q];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + AW'(1);
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end
endmodule

module itc_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins to the converter
    itc_if.host link
);
    import itc_pkg::*;

    typedef enum {P_IDLE, P_LOW} itc_pulse_t;
    typedef enum {R_IDLE, R_LOW, R_PUSH, R_HIGH} itc_read_t;

    function automatic logic regHit(input logic [7:0] a);
        regHit = (a == REG_CTRL) || (a == REG_CMD) || (a == REG_STATUS) || (a == REG_DATA);
    endfunction

    localparam logic [7:0] FRAME_LOAD = 8'(FRAME_BITS);
    localparam logic [4:0] WORD_FULL = 5'(RES_W);

    logic [2:0] ctrl_q;
    logic pulseReq_q;
    logic [31:0] prdata_q;
    logic wrEn;
    logic [1:0] meta_q;
    logic [1:0] sync_q;
    logic readyNSync;
    logic dataSync;
    itc_pulse_t pState_q;
    logic testOut_q;
    logic [AGE_W-1:0] testAge_q;
    logic sideOut_q;
    logic [AGE_W-1:0] sideAge_q;
    logic sidePending;
    logic sideGo;
    logic testGo;
    logic pulseDone;
    itc_read_t rState_q;
    logic shiftClk_q;
    logic [2:0] phase_q;
    logic [7:0] bitsLeft_q;
    logic [4:0] wordBits_q;
    logic [RES_W-1:0] word_q;
    logic [2:0] discard_q;
    logic holdClk;
    logic wordDone;
    logic fifoInReady;
    logic fifoOutValid;
    logic [RES_W-1:0] fifoOutData;
    logic busy;

    assign wrEn = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~regHit(paddr);
    assign prdata = prdata_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wrEn && paddr == REG_CTRL) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    // A new pulse request wins over the completion of the previous one.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulseReq_q <= 1'b0;
        end else if (wrEn && paddr == REG_CMD && pwdata[CMD_PULSE_BIT]) begin
            pulseReq_q <= 1'b1;
        end else if (pulseDone) begin
            pulseReq_q <= 1'b0;
        end
    end

    assign busy = pulseReq_q | sidePending | (pState_q != P_IDLE) | (rState_q != R_IDLE);

    // Read data is captured in the setup cycle so it comes from a flip-flop.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_CTRL: prdata_q <= {29'h00000000, ctrl_q};
                REG_STATUS: prdata_q <= {28'h0000000, discard_q != 3'h0, fifoOutValid, busy, ~readyNSync};
                REG_DATA: prdata_q <= {12'h000, fifoOutData};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 2'h1;
            sync_q <= 2'h1;
        end else begin
            meta_q <= {link.serialDataOut, link.resultReadyN};
            sync_q <= meta_q;
        end
    end

    assign readyNSync = sync_q[0];
    assign dataSync = sync_q[1];

    assign sidePending = sideOut_q != ctrl_q[CTRL_SIDE_BIT];
    assign sideGo = sidePending && pState_q == P_IDLE && !shiftClk_q
                    && testAge_q >= (testOut_q ? EDGE_TO_SIDE_AGE : SETUP_AGE);
    assign testGo = testOut_q != ctrl_q[CTRL_TEST_BIT] && !sideGo && sideAge_q >= SETUP_AGE
                    && testAge_q >= (testOut_q ? TEST_HIGH_AGE : TEST_LOW_AGE);
    assign pulseDone = (pState_q == P_LOW && testAge_q >= TEST_LOW_AGE)
                       || (pState_q == P_IDLE && pulseReq_q && !ctrl_q[CTRL_TEST_BIT]);

    // Side edges leave a flip-flop on the system clock, so they stay aligned to it.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sideOut_q <= 1'b0;
            sideAge_q <= '0;
        end else if (sideGo) begin
            sideOut_q <= ctrl_q[CTRL_SIDE_BIT];
            sideAge_q <= '0;
        end else if (sideAge_q != '1) begin
            sideAge_q <= sideAge_q + AGE_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pState_q <= P_IDLE;
            testOut_q <= 1'b0;
            testAge_q <= '0;
        end else begin
            if (testAge_q != '1) begin
                testAge_q <= testAge_q + AGE_W'(1);
            end
            case (pState_q)
                P_IDLE: begin
                    if (pulseReq_q && testOut_q && ctrl_q[CTRL_TEST_BIT] && !sidePending
                        && testAge_q >= TEST_HIGH_AGE && sideAge_q >= SETUP_AGE) begin
                        testOut_q <= 1'b0;
                        testAge_q <= '0;
                        pState_q <= P_LOW;
                    end else if (testGo && !pulseReq_q) begin
                        testOut_q <= ctrl_q[CTRL_TEST_BIT];
                        testAge_q <= '0;
                    end
                end
                P_LOW: begin
                    if (testAge_q >= TEST_LOW_AGE) begin
                        testOut_q <= 1'b1;
                        testAge_q <= '0;
                        pState_q <= P_IDLE;
                    end
                end
                default: pState_q <= P_IDLE;
            endcase
        end
    end

    assign holdClk = sidePending || sideAge_q < SETUP_AGE;
    assign wordDone = wordBits_q == WORD_FULL && (discard_q != 3'h0 || fifoInReady);

    // The shift clock has its own pace, unrelated to the converter's divider.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rState_q <= R_IDLE;
            shiftClk_q <= 1'b0;
            phase_q <= 3'h0;
            bitsLeft_q <= 8'h00;
            wordBits_q <= 5'h00;
            word_q <= {RES_W{1'b0}};
        end else begin
            case (rState_q)
                R_IDLE: begin
                    if (!readyNSync && !holdClk) begin
                        rState_q <= R_LOW;
                        phase_q <= 3'h0;
                        bitsLeft_q <= FRAME_LOAD;
                        wordBits_q <= 5'h00;
                    end
                end
                R_LOW: begin
                    if (phase_q == SHIFT_HALF_LAST) begin
                        word_q <= {word_q[RES_W-2:0], dataSync};
                        wordBits_q <= wordBits_q + 5'h01;
                        rState_q <= R_PUSH;
                    end else begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
                R_PUSH: begin
                    if (wordDone) begin
                        wordBits_q <= 5'h00;
                    end else if (wordBits_q != WORD_FULL && !holdClk) begin
                        shiftClk_q <= 1'b1;
                        phase_q <= 3'h0;
                        rState_q <= R_HIGH;
                    end
                end
                R_HIGH: begin
                    if (phase_q == SHIFT_HALF_LAST) begin
                        shiftClk_q <= 1'b0;
                        phase_q <= 3'h0;
                        bitsLeft_q <= bitsLeft_q - 8'h01;
                        rState_q <= (bitsLeft_q == 8'h01) ? R_IDLE : R_LOW;
                    end else begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
                default: rState_q <= R_IDLE;
            endcase
        end
    end

    // Leaving test mode arms a discard count; the arm wins over a frame ending.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_q <= 3'h0;
        end else if (pState_q == P_IDLE && testGo && !pulseReq_q && testOut_q) begin
            discard_q <= DISCARD_FRAMES;
        end else if (rState_q == R_HIGH && phase_q == SHIFT_HALF_LAST && bitsLeft_q == 8'h01
                     && discard_q != 3'h0) begin
            discard_q <= discard_q - 3'h1;
        end
    end

    itc_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(rState_q == R_PUSH && wordBits_q == WORD_FULL && discard_q == 3'h0),
        .inReady(fifoInReady),
        .inData(word_q),
        .outValid(fifoOutValid),
        .outReady(psel && penable && !pwrite && paddr == REG_DATA),
        .outData(fifoOutData)
    );

    assign link.sideSelect = sideOut_q;
    assign link.testPin = testOut_q;
    assign link.sysclkQuarterDividerSelect = ctrl_q[CTRL_DIV_BIT];
    assign link.serialShiftClock = shiftClk_q;
    assign link.cascadeIn = 1'b0;
endmodule

// ===== test/itc_link_sva.sv
// Purpose: Link timing checks.
// Assumes: One clock for both ends.
// Notes: Ages saturate, so long gaps never wrap.
`timescale 1ns/10ps
module itc_link_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Link
    input wire logic sideSelect,
    input wire logic testPin,
    input wire logic serialShiftClock,
    input wire logic cascadeIn,
    input wire logic serialDataOut,
    input wire logic resultReadyN
);
    logic [7:0] tAge_q;
    logic [7:0] sAge_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_low3;
        !serialShiftClock [*3];
    endsequence
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tAge_q <= 8'hFF;
        end else begin
            tAge_q <= $changed(testPin) ? 8'h00 : tAge_q + 8'(tAge_q != 8'hFF);
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sAge_q <= 8'hFF;
        end else begin
            sAge_q <= $rose(serialShiftClock) ? 8'h00 : sAge_q + 8'(sAge_q != 8'hFF);
        end
    end
    AST_SIDE_CLK_LOW: assert property ($changed(sideSelect) |-> !serialShiftClock) else $error("shift clock high at side edge");
    AST_SIDE_PAUSE: assert property ($changed(sideSelect) |=> s_low3) else $error("shift clock not paused");
    AST_TEST_TO_SIDE: assert property ($changed(sideSelect) |-> tAge_q >= (testPin ? 8'h18 : 8'h02)) else $error("side edge too soon");
    AST_TEST_PHASE: assert property ($changed(testPin) |-> tAge_q >= 8'h18) else $error("test phase too short");
    AST_SHIFT_HIGH: assert property ($rose(serialShiftClock) |=> serialShiftClock [*3]) else $error("shift high short");
    AST_SHIFT_LOW: assert property ($fell(serialShiftClock) |=> s_low3) else $error("shift low short");
    AST_READY_RISE: assert property ($rose(resultReadyN) |-> sAge_q <= 8'h04) else $error("ready rose unshifted");
    AST_DOUT_CAUSE: assert property ($changed(serialDataOut) |-> sAge_q <= 8'h04 or ##[0:2] !resultReadyN) else $error("data moved alone");
    AST_CASCADE_ZERO: assert property (cascadeIn == 1'b0) else $error("cascade not low");
endmodule

// ===== test/testbench.sv
// Purpose: Test mode charge packets through both ends.
// Assumes: Zero wait APB.
// Notes: Side edges are timed loosely; the host gates them.
`timescale 1ns/10ps
module testbench;
    import itc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [IN_W-1:0] cur [4] = '{default: '0};
    logic tm;
    logic sa;
    logic [31:0] seed = 32'h00008F0E;
    logic [31:0] rd;
    logic er;
    logic [31:0] w [$];
    int n_errors = 0;
    int n_compared = 0;
    itc_if itc_if_i();
    itc_device itc_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .link(itc_if_i), .currentInputOne(cur[0]),
        .currentInputTwo(cur[1]), .currentInputThree(cur[2]), .currentInputFour(cur[3]),
        .testModeActive(tm), .integratingSideA(sa), .nonContinuous());
    itc_host itc_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(itc_if_i));
    itc_link_sva itc_link_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .sideSelect(itc_if_i.sideSelect),
        .testPin(itc_if_i.testPin), .serialShiftClock(itc_if_i.serialShiftClock), .cascadeIn(itc_if_i.cascadeIn),
        .serialDataOut(itc_if_i.serialDataOut), .resultReadyN(itc_if_i.resultReadyN));
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] expw(int i, int k, int m);
        return 32'(((i % 2 == 0) ? m : k) * int'(PACKET_CODE));
    endfunction
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            n_errors++;
            complete_run();
        end
    endtask
    task automatic run(input logic dv);
        int k;
        int m;
        int i;
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 4; c++) cur[c] <= IN_W'(rnd());
        k = int'(rnd() % 32'h3) + 1;
        m = int'(rnd() % 32'h3);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        apb(1'b0, REG_CMD, 32'h0);
        chk("cmd", rd, 32'h0);
        apb(1'b1, REG_CTRL, {29'h0, dv, 2'h2});
        repeat (80) @(posedge sys_clk);
        for (int e = 0; e < 4; e++) begin
            apb(1'b1, REG_CTRL, {29'h0, dv, 1'b1, 1'(e % 2 == 0)});
            repeat (80) @(posedge sys_clk);
            repeat (e == 1 ? k : (e == 2 ? m : 0)) begin
                apb(1'b1, REG_CMD, 32'h1);
                repeat (80) @(posedge sys_clk);
            end
        end
        chk("mode", {sa, tm}, 32'h1);
        w.delete();
        i = 0;
        while (w.size() < 16 && i < 3000) begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rd[2] === 1'b1) begin
                apb(1'b0, REG_DATA, 32'h0);
                w.push_back({12'h0, rd[19:0]});
            end
            i++;
        end
        if (i >= 3000) begin
            n_errors++;
            complete_run();
        end
        for (int j = 0; j < 8; j += 2) chk("zero", w[j], 32'h0);
        for (int j = 8; j < 16; j++) chk("packet", w[j], expw(j, k, m));
        apb(1'b1, REG_CTRL, {29'h0, dv, 2'h0});
        repeat (5) @(posedge sys_clk);
        apb(1'b0, REG_STATUS, 32'h0);
        chk("discard", rd[3], 32'h1);
        $display("test div %0d done", dv);
    endtask
    initial begin
        run(1'b0);
        run(1'b1);
        complete_run();
    end
endmodule
